// [tb/tb_top.sv]
// tb_top: self-checking bench for the pll configuration register bank
`timescale 1ns/1ns
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin num_errors++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); end end
module tb_top;
    import pcr_pkg::*;
    // ****************
    // stimulus, mirrors and queues
    // ****************
    logic sys_clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [7:0] avs_address_i = 8'h00;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0;
    logic [3:0] avs_byteenable_i = 4'hF;
    logic [2:0] sel = 3'h0; // state pins, bit0 first
    logic [31:0] avs_readdata_o;
    logic avs_waitrequest_o;
    logic [1:0] band0, band1;
    pcr_pll3_cfg_t cfg;
    int num_errors = 0;
    int compares = 0;
    logic [31:0] seed = 32'h8FE02FA1;
    logic [31:0] rd_q[$]; // expected read data
    logic [17:0] ob_q[$]; // expected {bands, pll3 cfg}
    time due_q[$];
    logic [31:0] e_rd;
    logic [17:0] e_ob;
    logic [1:0] m0 = 2'h0, m1 = 2'h0; // mirrors of what the design should hold
    logic [23:0] m_amt = 24'h0;
    logic [7:0] m_fs = 8'h00, v2b = 8'h00, d;
    logic m_dir = 1'b0;
    localparam logic [7:0] REGS [10] = '{PCR_IDX_PLL2_SET0_Q_P_RANGE, PCR_IDX_PLL2_SET1_N_HIGH,
        PCR_IDX_PLL2_SET1_N_LOW_R_HIGH, PCR_IDX_PLL2_SET1_R_LOW_Q_HIGH,
        PCR_IDX_PLL2_SET1_Q_P_RANGE, PCR_IDX_PLL3_SPREAD_STATES_A, PCR_IDX_PLL3_SPREAD_STATES_B,
        PCR_IDX_PLL3_SPREAD_STATES_C, PCR_IDX_PLL3_FREQ_SET_SELECT, PCR_IDX_PLL3_CONTROL};
    always #2 sys_clk_i = ~sys_clk_i;
    pcr_bank i_pcr_bank (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .state_select_bit0_i(sel[0]), .state_select_bit1_i(sel[1]), .state_select_bit2_i(sel[2]),
        .pll2_set0_band_o(band0), .pll2_set1_band_o(band1), .pll3_cfg_o(cfg));
    // ****************
    // helpers
    // ****************
    function automatic logic [31:0] lfsr(logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    // code 6 has no center reading, so it shows as off there
    function automatic logic [17:0] exp_out(int k);
        logic [2:0] a;
        logic on;
        a = m_amt[3*k +: 3];
        on = (a != 3'h0) && !(a == 3'h6 && m_dir);
        return {m0, m1, a, m_dir, m_fs[k], on, on ? ((a == 3'h7) ? 8'hC8 : 8'h19 * a) : 8'h00};
    endfunction
    task automatic complete_run();
        $display("comparisons %0d errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // one avalon access; held until waitrequest is seen low at a rising edge
    task automatic acc(bit wr, logic [7:0] a, logic [7:0] dat, logic [7:0] e, logic [3:0] be);
        int n;
        @(posedge sys_clk_i);
        seed = lfsr(seed);
        avs_address_i <= a;
        avs_write_i <= wr;
        avs_read_i <= !wr;
        avs_writedata_i <= {seed[31:8], dat}; // upper lanes carry noise, ignored
        avs_byteenable_i <= be;
        if (!wr) rd_q.push_back({24'h0, e});
        n = 0;
        // waitrequest is read at the rising edge, as the slave presents it there
        do begin @(posedge sys_clk_i); n++; end while (avs_waitrequest_o !== 1'b0 && n < 20);
        if (avs_waitrequest_o !== 1'b0) begin num_errors++; complete_run(); end
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
    endtask
    // pick a state and note what the outputs must show two edges later
    task automatic obs(int k);
        @(posedge sys_clk_i);
        sel <= k[2:0];
        ob_q.push_back(exp_out(k));
        due_q.push_back($time + 8);
    endtask
    // ****************
    // monitor: compares oldest note with each result
    // ****************
    always @(posedge sys_clk_i) begin
        if (avs_read_i && avs_waitrequest_o === 1'b0) begin
            e_rd = (rd_q.size() > 0) ? rd_q.pop_front() : 32'hFFFFFFFF;
            `CHK("readdata", e_rd, avs_readdata_o)
        end
        if (due_q.size() > 0 && $time >= due_q[0]) begin
            void'(due_q.pop_front());
            e_ob = ob_q.pop_front();
            `CHK("pll outputs", e_ob, {band0, band1, cfg})
        end
    end
    initial begin #400000; num_errors++; complete_run(); end
    // ****************
    // main sequence
    // ****************
    initial begin
        repeat (12) @(posedge sys_clk_i);
        reset_n_i <= 1'b1;
        foreach (REGS[i]) acc(0, REGS[i], 8'h00, 8'h00, 4'hF); // reset values zero
        obs(7);
        // every register written and read back; control keeps bit 7 only
        foreach (REGS[i]) begin
            d = seed[7:0];
            if (REGS[i] == PCR_IDX_PLL2_SET1_N_HIGH) d[7] = 1'b1;
            if (REGS[i] == PCR_IDX_PLL2_SET1_R_LOW_Q_HIGH) d[1] = 1'b1;
            acc(1, REGS[i], d, 8'h00, 4'hF);
            acc(0, REGS[i], 8'h00, (REGS[i] == PCR_IDX_PLL3_CONTROL) ? (d & 8'h80) : d, 4'hF);
            if (REGS[i] == PCR_IDX_PLL2_SET0_Q_P_RANGE) m0 = d[1:0];
            if (REGS[i] == PCR_IDX_PLL2_SET1_Q_P_RANGE) m1 = d[1:0];
        end
        // two rounds cover every amount code in both directions, then random
        for (int r = 0; r < 4; r++) begin
            seed = lfsr(seed);
            m_amt = (r < 2) ? 24'hFAC688 : seed[23:0];
            m_fs = seed[31:24];
            m_dir = r[0];
            acc(1, PCR_IDX_PLL3_SPREAD_STATES_A, m_amt[23:16], 8'h00, 4'hF);
            acc(1, PCR_IDX_PLL3_SPREAD_STATES_B, m_amt[15:8], 8'h00, 4'hF);
            acc(1, PCR_IDX_PLL3_SPREAD_STATES_C, m_amt[7:0], 8'h00, 4'hF);
            acc(1, PCR_IDX_PLL3_FREQ_SET_SELECT, m_fs, 8'h00, 4'hF);
            acc(1, PCR_IDX_PLL3_CONTROL, {m_dir, seed[6:0]}, 8'h00, 4'hF);
            for (int k = 0; k < 8; k++) obs(k);
        end
        // all four band codes on both sets, in opposite order
        for (int b = 0; b < 4; b++) begin
            seed = lfsr(seed);
            m0 = b[1:0];
            m1 = 2'h3 - b[1:0];
            v2b = {seed[7:2], m0};
            acc(1, PCR_IDX_PLL2_SET0_Q_P_RANGE, v2b, 8'h00, 4'hF);
            acc(1, PCR_IDX_PLL2_SET1_Q_P_RANGE, {seed[15:10], m1}, 8'h00, 4'hF);
            obs(b + 4);
        end
        // refused writes: unmapped place and lane 0 disabled
        acc(1, 8'h40, 8'hA5, 8'h00, 4'hF);
        acc(0, 8'h40, 8'h00, 8'h00, 4'hF);
        acc(1, PCR_IDX_PLL2_SET0_Q_P_RANGE, ~v2b, 8'h00, 4'hE);
        acc(0, PCR_IDX_PLL2_SET0_Q_P_RANGE, 8'h00, v2b, 4'hF);
        obs(0);
        repeat (4) @(posedge sys_clk_i);
        // a note never taken off its queue means an answer never came
        if (ob_q.size() != 0 || rd_q.size() != 0) num_errors++;
        complete_run();
    end
endmodule // tb_top

// [verilog/pcr_bank.sv]
// pcr_bank: pll2 band/parameter registers and pll3 per-state spread registers
//
// The implementer's own choice: the Avalon-MM slave port.
`timescale 1ns/1ns
module pcr_bank
    import pcr_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    // avalon-mm slave
    input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // state select pins
    input wire logic state_select_bit0_i,
    input wire logic state_select_bit1_i,
    input wire logic state_select_bit2_i,
    // pll2 band outputs
    output logic [1:0] pll2_set0_band_o,
    output logic [1:0] pll2_set1_band_o,
    // pll3 selected configuration
    output pcr_pll3_cfg_t pll3_cfg_o
);
    // ********************************************
    // storage
    // ********************************************
    logic [7:0] set0_qpr_q; // set0 q low, p, band
    logic [7:0] set1_nh_q; // set1 n high
    logic [7:0] set1_nlrh_q; // set1 n low, r high
    logic [7:0] set1_rlqh_q; // set1 r low, q high
    logic [7:0] set1_qpr_q; // set1 q low, p, band
    logic [7:0] ssc_a_q; // spread codes states 7..5
    logic [7:0] ssc_b_q; // spread codes states 5..2
    logic [7:0] ssc_c_q; // spread codes states 2..0
    logic [7:0] fs_q; // freq set pick per state
    logic pll3_spread_direction_q; // 0 down, 1 center
    logic ack_q; // one-cycle answer
    logic [7:0] rd_byte; // addressed read value
    logic wr_hit; // write lands on this answer edge
    logic [23:0] ssc_flat; // all eight amount fields
    logic [2:0] pll3_spread_amount [PCR_NUM_STATES]; // per state
    logic [2:0] sel; // current state index
    logic [2:0] amt_d;
    logic [7:0] pct_d;
    // a write lands only where the master sees waitrequest low, never earlier
    assign wr_hit = avs_write_i && ack_q && avs_byteenable_i[0];
    assign ssc_flat = {ssc_a_q, ssc_b_q, ssc_c_q};
    assign sel = {state_select_bit2_i, state_select_bit1_i, state_select_bit0_i};
    // ********************************************
    // per-state unpack of the packed spread fields
    // ********************************************
    for (genvar g = 0; g < PCR_NUM_STATES; g++) begin : g_amt
        assign pll3_spread_amount[g] = ssc_flat[g*PCR_AMT_W +: PCR_AMT_W];
    end
    // ********************************************
    // bus handshake: every access answered one cycle later
    // ********************************************
    // waitrequest is high until the answer cycle, so each access costs two cycles
    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            ack_q <= 1'b0;
            avs_waitrequest_o <= 1'b1; // busy until an access is answered
        end else begin
            ack_q <= (avs_read_i || avs_write_i) && !ack_q;
            // registered copy of the inverted answer, so the pin comes from a flop
            avs_waitrequest_o <= !((avs_read_i || avs_write_i) && !ack_q);
        end
    end
    // ********************************************
    // register writes: software owns the parameter limits
    // ********************************************
    // values out of range are stored as written; the synthesizer core must not be
    // fed them, but checking here would hide a software fault
    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            set0_qpr_q <= PCR_RST_BYTE;
            set1_nh_q <= PCR_RST_BYTE;
            set1_nlrh_q <= PCR_RST_BYTE;
            set1_rlqh_q <= PCR_RST_BYTE;
            set1_qpr_q <= PCR_RST_BYTE;
            ssc_a_q <= PCR_RST_BYTE;
            ssc_b_q <= PCR_RST_BYTE;
            ssc_c_q <= PCR_RST_BYTE;
            fs_q <= PCR_RST_BYTE;
            pll3_spread_direction_q <= 1'b0;
        end else if (wr_hit) begin
            case (avs_address_i)
                PCR_IDX_PLL2_SET0_Q_P_RANGE: set0_qpr_q <= avs_writedata_i[7:0];
                PCR_IDX_PLL2_SET1_N_HIGH: set1_nh_q <= avs_writedata_i[7:0];
                PCR_IDX_PLL2_SET1_N_LOW_R_HIGH: set1_nlrh_q <= avs_writedata_i[7:0];
                PCR_IDX_PLL2_SET1_R_LOW_Q_HIGH: set1_rlqh_q <= avs_writedata_i[7:0];
                PCR_IDX_PLL2_SET1_Q_P_RANGE: set1_qpr_q <= avs_writedata_i[7:0];
                PCR_IDX_PLL3_SPREAD_STATES_A: ssc_a_q <= avs_writedata_i[7:0];
                PCR_IDX_PLL3_SPREAD_STATES_B: ssc_b_q <= avs_writedata_i[7:0];
                PCR_IDX_PLL3_SPREAD_STATES_C: ssc_c_q <= avs_writedata_i[7:0];
                PCR_IDX_PLL3_FREQ_SET_SELECT: fs_q <= avs_writedata_i[7:0];
                PCR_IDX_PLL3_CONTROL: pll3_spread_direction_q <= avs_writedata_i[PCR_DIR_BIT];
                default: ; // unmapped: write ignored
            endcase
        end
    end
    // ********************************************
    // read mux: unmapped addresses read zero
    // ********************************************
    always_comb begin
        case (avs_address_i)
            PCR_IDX_PLL2_SET0_Q_P_RANGE: rd_byte = set0_qpr_q;
            PCR_IDX_PLL2_SET1_N_HIGH: rd_byte = set1_nh_q;
            PCR_IDX_PLL2_SET1_N_LOW_R_HIGH: rd_byte = set1_nlrh_q;
            PCR_IDX_PLL2_SET1_R_LOW_Q_HIGH: rd_byte = set1_rlqh_q;
            PCR_IDX_PLL2_SET1_Q_P_RANGE: rd_byte = set1_qpr_q;
            PCR_IDX_PLL3_SPREAD_STATES_A: rd_byte = ssc_a_q;
            PCR_IDX_PLL3_SPREAD_STATES_B: rd_byte = ssc_b_q;
            PCR_IDX_PLL3_SPREAD_STATES_C: rd_byte = ssc_c_q;
            PCR_IDX_PLL3_FREQ_SET_SELECT: rd_byte = fs_q;
            PCR_IDX_PLL3_CONTROL: rd_byte = {pll3_spread_direction_q, 7'h00};
            default: rd_byte = 8'h00;
        endcase
    end
    // read data registered so it stands in the waitrequest-low cycle
    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            avs_readdata_o <= 32'h0000_0000;
        end else if (avs_read_i && !ack_q) begin
            avs_readdata_o <= {24'h000000, rd_byte};
        end
    end
    // ********************************************
    // pll2 band fields straight from storage
    // ********************************************
    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            pll2_set0_band_o <= PCR_BAND_BELOW_125;
            pll2_set1_band_o <= PCR_BAND_BELOW_125;
        end else begin
            pll2_set0_band_o <= set0_qpr_q[PCR_BAND_LSB +: 2];
            pll2_set1_band_o <= set1_qpr_q[PCR_BAND_LSB +: 2];
        end
    end
    // ********************************************
    // spread amount decode in hundredths of a percent
    // ********************************************
    // code 110 is only legal as down spread; in center mode it is treated as off
    always_comb begin
        amt_d = pll3_spread_amount[sel];
        case (amt_d)
            3'h0: pct_d = 8'h00;
            3'h1: pct_d = 8'h19;
            3'h2: pct_d = 8'h32;
            3'h3: pct_d = 8'h4B;
            3'h4: pct_d = 8'h64;
            3'h5: pct_d = 8'h7D;
            3'h6: pct_d = pll3_spread_direction_q ? 8'h00 : 8'h96;
            3'h7: pct_d = 8'hC8;
            default: pct_d = 8'h00;
        endcase
    end
    // selected state presented to pll3, registered
    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            pll3_cfg_o <= '0;
        end else begin
            pll3_cfg_o.amount <= amt_d;
            pll3_cfg_o.center <= pll3_spread_direction_q;
            pll3_cfg_o.freq_set <= fs_q[sel];
            pll3_cfg_o.spread_on <= (pct_d != 8'h00);
            pll3_cfg_o.percent_x100 <= pct_d;
        end
    end
    // ********************************************
    // checks
    // ********************************************
    AST_BAND0: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        ##1 pll2_set0_band_o == $past(set0_qpr_q[1:0]))
        else $error("set0 band does not follow register");
    AST_BAND1: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        ##1 pll2_set1_band_o == $past(set1_qpr_q[1:0]))
        else $error("set1 band does not follow register");
    AST_FS: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        ##1 pll3_cfg_o.freq_set == $past(fs_q[sel]))
        else $error("freq set pick wrong");
    AST_PCT7: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        amt_d == 3'h7 |=> pll3_cfg_o.percent_x100 == 8'hC8)
        else $error("code 7 not two percent");
    AST_PCT1: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        amt_d == 3'h1 |=> pll3_cfg_o.percent_x100 == 8'h19)
        else $error("code 1 not quarter percent");
    AST_SEL: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        ##1 pll3_cfg_o.amount == $past(ssc_flat[sel*3 +: 3]))
        else $error("state select wrong");
    AST_DIR: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        amt_d == 3'h6 && pll3_spread_direction_q |=> pll3_cfg_o.percent_x100 == 8'h00)
        else $error("code 6 used in center mode");
    AST_KEEP: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        !(avs_write_i && avs_address_i == PCR_IDX_PLL3_SPREAD_STATES_C) |=> $stable(ssc_c_q))
        else $error("spread storage changed without write");
    AST_ACK: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("access not answered in one cycle");
    // ********************************************
    // access steps as sequences
    // ********************************************
    // write taken: request seen while still busy, lane 0 enabled
    sequence s_wr_open;
        avs_write_i && avs_waitrequest_o && avs_byteenable_i[0];
    endsequence
    // write answered at the frequency select byte
    sequence s_wr_land;
        avs_write_i && !avs_waitrequest_o && avs_address_i == PCR_IDX_PLL3_FREQ_SET_SELECT;
    endsequence
    // read taken at the frequency select byte
    sequence s_rd_open;
        avs_read_i && avs_waitrequest_o && avs_address_i == PCR_IDX_PLL3_FREQ_SET_SELECT;
    endsequence
    AST_FS_STORE: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        s_wr_open ##1 s_wr_land |=> fs_q == $past(avs_writedata_i[7:0]))
        else $error("freq set byte not stored on answer edge");
    AST_RD_DATA: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        s_rd_open |=> !avs_waitrequest_o && avs_readdata_o == {24'h000000, fs_q})
        else $error("freq set byte not returned in answer cycle");
endmodule // pcr_bank

// [verilog/pcr_pkg.sv]
// pcr_pkg: offsets, field layouts and types of the pll configuration register bank
package pcr_pkg;
    // ********************************************
    // register offsets (byte addresses, used as they are on the bus)
    // ********************************************
    localparam logic [7:0] PCR_IDX_PLL2_SET0_Q_P_RANGE = 8'h2B;
    localparam logic [7:0] PCR_IDX_PLL2_SET1_N_HIGH = 8'h2C;
    localparam logic [7:0] PCR_IDX_PLL2_SET1_N_LOW_R_HIGH = 8'h2D;
    localparam logic [7:0] PCR_IDX_PLL2_SET1_R_LOW_Q_HIGH = 8'h2E;
    localparam logic [7:0] PCR_IDX_PLL2_SET1_Q_P_RANGE = 8'h2F;
    localparam logic [7:0] PCR_IDX_PLL3_SPREAD_STATES_A = 8'h30;
    localparam logic [7:0] PCR_IDX_PLL3_SPREAD_STATES_B = 8'h31;
    localparam logic [7:0] PCR_IDX_PLL3_SPREAD_STATES_C = 8'h32;
    localparam logic [7:0] PCR_IDX_PLL3_FREQ_SET_SELECT = 8'h33;
    localparam logic [7:0] PCR_IDX_PLL3_CONTROL = 8'h36;
    // ********************************************
    // reset values: every byte clears to zero
    // ********************************************
    localparam logic [7:0] PCR_RST_BYTE = 8'h00;
    // ********************************************
    // field layout
    // ********************************************
    localparam int PCR_BAND_LSB = 0;
    localparam int PCR_P_LSB = 2;
    localparam int PCR_Q_LSB = 5;
    localparam int PCR_DIR_BIT = 7;
    localparam int PCR_NUM_STATES = 8;
    localparam int PCR_AMT_W = 3;
    localparam int PCR_READ_LATENCY = 1;
    // band codes in ascending vco frequency
    typedef enum logic [1:0] {
        PCR_BAND_BELOW_125 = 2'h0,
        PCR_BAND_125_150 = 2'h1,
        PCR_BAND_150_175 = 2'h2,
        PCR_BAND_175_UP = 2'h3
    } pcr_band_t;
    // what pll3 sees for the selected state
    typedef struct packed {
        logic [2:0] amount;
        logic center;
        logic freq_set;
        logic spread_on;
        logic [7:0] percent_x100;
    } pcr_pll3_cfg_t;
endpackage
